//--- src/flash_spi_front.sv
// Device end: serial flash command front end on a sampled link clock
// Notes on behaviour
// - Works with clock modes zero and three
// - Inputs sampled on rising clock edge
// - Outputs change on falling clock edge
// - Host parks clock per chosen mode
// - Mode three: first rise takes first bit
// - Cycles counted falling edge to falling
// - Mode zero: first cycle starts at select
// - Dual output and dual io reads
// - Both data lines bidirectional in dual io
// - Reset only after enable then reset
// - Reset commands on current line width
// - Host leaves quad continuous read first
// - Status one powers up from stored copy
// - Stored status write needs write enable
// - Volatile enable makes volatile copy active
// - No four byte address mode reported
// - Table bytes E8h, 30h, C0h, 80h
// - Status reads for registers one, two
`timescale 1ns/100ps
module flash_spi_front
  import flash_spi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  flash_spi_if.flash link,
  // Status and events
  output logic [7:0] sr1_active,
  output logic soft_reset_pulse,
  output logic [23:0] read_addr
);
  import flash_spi_pkg::*;

  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_OUT, PH_WDATA, PH_IGNORE}
    phase_t;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic sclk_prev_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
      sclk_prev_q <= 1'b0;
    end else begin
      s1_q <= {link.sclk, link.cs_b, link.data_line_one, link.data_line_zero};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[3];
    end
  end
  wire cs_b_s = s2_q[2];
  wire rise = s2_q[3] & ~sclk_prev_q & ~cs_b_s;
  wire fall = ~s2_q[3] & sclk_prev_q & ~cs_b_s;
  wire in0 = s2_q[0];
  wire in1 = s2_q[1];

  // ****************************************
  // State
  // ****************************************
  phase_t phase_q, phase_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] op_q, op_d;
  logic [23:0] sh_q, sh_d;
  logic [7:0] out_q, out_d;
  logic dual_q, dual_d;
  logic [7:0] sr1_nv_q, sr1_nv_d;
  logic [7:0] sr1_vol_q, sr1_vol_d;
  logic vol_act_q, vol_act_d;
  logic wel_q, wel_d;
  logic vwen_q, vwen_d;
  logic rst_en_q, rst_en_d;
  logic soft_q, soft_d;
  logic [23:0] addr_q, addr_d;
  logic drv_q, drv_d;
  logic d0_q, d0_d;
  logic d1_q, d1_d;
  logic cs_prev_q;
  logic oe0_q;

  wire [7:0] sr1_cur = (vol_act_q ? sr1_vol_q : sr1_nv_q) | (wel_q ? SR1_WEL_MASK : 8'h00);
  wire cs_rise = cs_b_s & ~cs_prev_q;
  wire [7:0] op_next = {op_q[6:0], in0};
  wire is_dual_io = (op_next == OP_DUAL_IO);
  wire [7:0] addr_lo = sh_q[7:0];
  wire [7:0] param_byte = (addr_lo == PARAM_ADDR_6C) ? PARAM_6C :
    (addr_lo == PARAM_ADDR_6D) ? PARAM_6D :
    (addr_lo == PARAM_ADDR_6E) ? PARAM_6E :
    (addr_lo == PARAM_ADDR_6F) ? PARAM_6F : 8'hFF;
  wire [7:0] load_byte = (op_q == OP_READ_SR1) ? sr1_cur :
    (op_q == OP_READ_SR2) ? SR2_RESET :
    (op_q == OP_READ_PARAM) ? param_byte : 8'hFF;

  // ****************************************
  // Command sequencer
  // ****************************************
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    op_d = op_q;
    sh_d = sh_q;
    out_d = out_q;
    dual_d = dual_q;
    sr1_nv_d = sr1_nv_q;
    sr1_vol_d = sr1_vol_q;
    vol_act_d = vol_act_q;
    wel_d = wel_q;
    vwen_d = vwen_q;
    rst_en_d = rst_en_q;
    soft_d = 1'b0;
    addr_d = addr_q;
    drv_d = drv_q;
    d0_d = d0_q;
    d1_d = d1_q;
    if (cs_rise) begin
      // Command completes on deselect
      if (phase_q == PH_OPCODE && cnt_q == CNT_OPCODE) begin
        rst_en_d = (op_q == OP_RST_EN);
        if (op_q == OP_RESET && rst_en_q) begin
          soft_d = 1'b1;
          vol_act_d = 1'b0;
          wel_d = 1'b0;
          vwen_d = 1'b0;
        end
        if (op_q == OP_WRITE_EN) begin
          wel_d = 1'b1;
        end
        if (op_q == OP_VOL_WEN) begin
          vwen_d = 1'b1;
        end
      end else begin
        rst_en_d = 1'b0;
      end
      if (phase_q == PH_WDATA && cnt_q == CNT_OPCODE) begin
        if (vwen_q) begin
          sr1_vol_d = sh_q[7:0] & ~SR1_WEL_MASK;
          vol_act_d = 1'b1;
          vwen_d = 1'b0;
        end else if (wel_q) begin
          sr1_nv_d = sh_q[7:0] & ~SR1_WEL_MASK;
          sr1_vol_d = sh_q[7:0] & ~SR1_WEL_MASK;
          wel_d = 1'b0;
        end
      end
      phase_d = PH_OPCODE;
      cnt_d = 6'h00;
      dual_d = 1'b0;
      drv_d = 1'b0;
    end else if (rise) begin
      case (phase_q)
        PH_OPCODE: begin
          op_d = op_next;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == CNT_OPCODE - 6'h01) begin
            cnt_d = 6'h00;
            case (op_next)
              OP_DUAL_OUT, OP_DUAL_IO, OP_READ_PARAM: begin
                phase_d = PH_ADDR;
                dual_d = is_dual_io;
              end
              OP_READ_SR1, OP_READ_SR2: begin
                phase_d = PH_OUT;
                out_d = 8'h00;
              end
              OP_WRITE_SR: begin
                phase_d = PH_WDATA;
              end
              default: begin
                cnt_d = CNT_OPCODE;
              end
            endcase
          end
        end
        PH_ADDR: begin
          sh_d = dual_q ? {sh_q[21:0], in1, in0} : {sh_q[22:0], in0};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == (dual_q ? CNT_ADDR_DUAL : CNT_ADDR) - 6'h01) begin
            cnt_d = 6'h00;
            phase_d = PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          addr_d = sh_q;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == (dual_q ? CNT_DUMMY_DUAL : CNT_DUMMY) - 6'h01) begin
            cnt_d = 6'h00;
            phase_d = PH_OUT;
            dual_d = (op_q != OP_READ_PARAM);
          end
        end
        PH_WDATA: begin
          sh_d = {sh_q[22:0], in0};
          if (cnt_q != CNT_OPCODE) begin
            cnt_d = cnt_q + 6'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (fall && phase_q == PH_OUT) begin
      drv_d = 1'b1;
      if (cnt_q == 6'h00) begin
        out_d = load_byte;
      end
      if (dual_q) begin
        d1_d = (cnt_q == 6'h00) ? load_byte[7] : out_q[7];
        d0_d = (cnt_q == 6'h00) ? load_byte[6] : out_q[6];
        out_d = (cnt_q == 6'h00) ? {load_byte[5:0], 2'b00} : {out_q[5:0], 2'b00};
        cnt_d = (cnt_q == 6'h03) ? 6'h00 : cnt_q + 6'h01;
        if (cnt_q == 6'h03) begin
          out_d = 8'hFF;
        end
      end else begin
        d1_d = (cnt_q == 6'h00) ? load_byte[7] : out_q[7];
        out_d = (cnt_q == 6'h00) ? {load_byte[6:0], 1'b0} : {out_q[6:0], 1'b0};
        cnt_d = (cnt_q == 6'h07) ? 6'h00 : cnt_q + 6'h01;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= PH_OPCODE;
      cnt_q <= 6'h00;
      op_q <= 8'h00;
      sh_q <= 24'h000000;
      out_q <= 8'h00;
      dual_q <= 1'b0;
      sr1_nv_q <= SR1_NV_RESET;
      sr1_vol_q <= SR1_NV_RESET;
      vol_act_q <= 1'b0;
      wel_q <= 1'b0;
      vwen_q <= 1'b0;
      rst_en_q <= 1'b0;
      soft_q <= 1'b0;
      addr_q <= 24'h000000;
      drv_q <= 1'b0;
      d0_q <= 1'b0;
      d1_q <= 1'b0;
      cs_prev_q <= 1'b1;
      oe0_q <= 1'b0;
      sr1_active <= SR1_NV_RESET;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      sh_q <= sh_d;
      out_q <= out_d;
      dual_q <= dual_d;
      sr1_nv_q <= sr1_nv_d;
      sr1_vol_q <= sr1_vol_d;
      vol_act_q <= vol_act_d;
      wel_q <= wel_d;
      vwen_q <= vwen_d;
      rst_en_q <= rst_en_d;
      soft_q <= soft_d;
      addr_q <= addr_d;
      drv_q <= drv_d & ~cs_b_s;
      d0_q <= d0_d;
      d1_q <= d1_d;
      cs_prev_q <= cs_b_s;
      oe0_q <= drv_d & dual_d & ~cs_b_s;
      sr1_active <= sr1_cur;
    end
  end

  assign soft_reset_pulse = soft_q;
  assign read_addr = addr_q;
  assign link.d0_f = d0_q;
  assign link.d1_f = d1_q;
  assign link.d0_f_oe = oe0_q;
  assign link.d1_f_oe = drv_q;
endmodule

//--- src/flash_spi_pkg.sv
// Shared constants for the serial flash front end and its host end
package flash_spi_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_READ_SR1 = 8'h05;
  localparam logic [7:0] OP_READ_SR2 = 8'h35;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_VOL_WEN = 8'h50;
  localparam logic [7:0] OP_WRITE_SR = 8'h01;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_READ_PARAM = 8'h5A;
  // ****************************************
  // Parameter table
  // ****************************************
  localparam logic [7:0] PARAM_ADDR_6C = 8'h6C;
  localparam logic [7:0] PARAM_ADDR_6D = 8'h6D;
  localparam logic [7:0] PARAM_ADDR_6E = 8'h6E;
  localparam logic [7:0] PARAM_ADDR_6F = 8'h6F;
  localparam logic [7:0] PARAM_6C = 8'hE8;
  localparam logic [7:0] PARAM_6D = 8'h30;
  localparam logic [7:0] PARAM_6E = 8'hC0;
  localparam logic [7:0] PARAM_6F = 8'h80;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] SR1_NV_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR1_WEL_MASK = 8'h02;
  localparam logic [5:0] CNT_OPCODE = 6'h08;
  localparam logic [5:0] CNT_ADDR = 6'h18;
  localparam logic [5:0] CNT_ADDR_DUAL = 6'h0C;
  localparam logic [5:0] CNT_DUMMY = 6'h08;
  localparam logic [5:0] CNT_DUMMY_DUAL = 6'h04;
  localparam logic [7:0] HOST_DIV_HALF = 8'h04;
endpackage

//--- src/flash_spi_if.sv
// Link wires between the flash front end and the host master
`timescale 1ns/100ps
interface flash_spi_if;
  logic sclk;
  logic cs_b;
  logic d0_h;
  logic d0_h_oe;
  logic d1_h;
  logic d1_h_oe;
  logic d0_f;
  logic d0_f_oe;
  logic d1_f;
  logic d1_f_oe;
  // Resolved line levels, pulled high when nobody drives
  wire data_line_zero = d0_h_oe ? d0_h : (d0_f_oe ? d0_f : 1'b1);
  wire data_line_one = d1_h_oe ? d1_h : (d1_f_oe ? d1_f : 1'b1);
  modport host (output sclk, output cs_b, output d0_h, output d0_h_oe, output d1_h,
    output d1_h_oe, input data_line_zero, input data_line_one);
  modport flash (input sclk, input cs_b, output d0_f, output d0_f_oe, output d1_f,
    output d1_f_oe, input data_line_zero, input data_line_one);
endinterface

//--- src/flash_spi_host.sv
// Host end: simple master that sends one command frame and reads back one byte
`timescale 1ns/100ps
module flash_spi_host
  import flash_spi_pkg::*;
#(
  parameter logic [7:0] DIV_HALF = HOST_DIV_HALF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request
  input wire logic start,
  input wire logic mode3,
  input wire logic [7:0] opcode,
  input wire logic [23:0] addr,
  input wire logic [1:0] kind,
  input wire logic [7:0] wdata,
  // Answer
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  // Link
  flash_spi_if.host link
);
  import flash_spi_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} hstate_t;
  // kind: 0 opcode only, 1 opcode+1 byte read, 2 write byte, 3 addressed read

  hstate_t st_q;
  logic [7:0] div_q;
  logic [6:0] bit_q;
  logic [6:0] nbits_q;
  logic [39:0] tx_q;
  logic [7:0] rx_q;
  logic sclk_q, cs_b_q, mosi_q, mode3_q, done_q;
  logic oe_q;
  logic rd_q;
  logic [1:0] r1_q, r2_q;

  wire tick = (div_q == DIV_HALF - 8'h01);
  wire [6:0] nb = (kind == 2'h0) ? 7'd8 : (kind == 2'h3) ? 7'd48 : 7'd16;

  // ****************************************
  // Sampled data line
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r1_q <= 2'b11;
      r2_q <= 2'b11;
    end else begin
      r1_q <= {link.data_line_one, link.data_line_zero};
      r2_q <= r1_q;
    end
  end

  // ****************************************
  // Frame engine
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= H_IDLE;
      div_q <= 8'h00;
      bit_q <= 7'h00;
      nbits_q <= 7'h00;
      tx_q <= 40'h0;
      rx_q <= 8'h00;
      sclk_q <= 1'b0;
      cs_b_q <= 1'b1;
      mosi_q <= 1'b1;
      mode3_q <= 1'b0;
      done_q <= 1'b0;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done_q <= 1'b0;
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      case (st_q)
        H_IDLE: begin
          sclk_q <= mode3;
          if (start) begin
            mode3_q <= mode3;
            sclk_q <= mode3;
            cs_b_q <= 1'b0;
            oe_q <= 1'b1;
            rd_q <= kind[0];
            tx_q <= {opcode, (kind == 2'h3) ? addr : {wdata, 16'h0000}, 8'h00};
            mosi_q <= opcode[7];
            nbits_q <= nb;
            bit_q <= 7'h00;
            div_q <= 8'h00;
            st_q <= H_RUN;
          end
        end
        H_RUN: begin
          if (tick) begin
            if (bit_q == nbits_q && sclk_q == mode3_q) begin
              // Last bit taken and clock parked at its idle level
              cs_b_q <= 1'b1;
              oe_q <= 1'b0;
              st_q <= H_GAP;
            end else if (!sclk_q) begin
              sclk_q <= 1'b1;
              rx_q <= {rx_q[6:0], r2_q[1]};
              bit_q <= bit_q + 7'h01;
              tx_q <= {tx_q[38:0], 1'b0};
              // Free line zero before the flash may turn it around
              if (rd_q && bit_q == nbits_q - 7'h09) begin
                oe_q <= 1'b0;
              end
            end else begin
              sclk_q <= 1'b0;
              mosi_q <= tx_q[39];
            end
          end
        end
        H_GAP: begin
          if (tick) begin
            done_q <= 1'b1;
            rdata <= rx_q;
            st_q <= H_IDLE;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign busy = (st_q != H_IDLE);
  assign done = done_q;
  assign link.sclk = sclk_q;
  assign link.cs_b = cs_b_q;
  assign link.d0_h = mosi_q;
  assign link.d0_h_oe = oe_q;
  assign link.d1_h = 1'b0;
  assign link.d1_h_oe = 1'b0;
endmodule

//--- test/flash_spi_monitor.sv
// Concurrent checks on the link between the flash front end and the host end
`timescale 1ns/100ps
module flash_spi_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic d0_h,
  input wire logic d0_h_oe,
  input wire logic d1_h_oe,
  input wire logic d0_f_oe,
  input wire logic d1_f,
  input wire logic d1_f_oe
);
  // ****************************************
  // Link clock rises seen within a frame
  // ****************************************
  logic sclk_q;
  logic [5:0] rise_cnt_q;
  logic [5:0] rise_cnt_d;
  wire sclk_rise = sclk && !sclk_q;
  assign rise_cnt_d = cs_b ? 6'h00 :
    (sclk_rise && rise_cnt_q != 6'h3F) ? rise_cnt_q + 6'h01 : rise_cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      rise_cnt_q <= 6'h00;
    end else begin
      sclk_q <= sclk;
      rise_cnt_q <= rise_cnt_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_no_line_fight: assert property (!(d0_h_oe && d0_f_oe) && !(d1_h_oe && d1_f_oe))
    else $error("both ends drive one data line");
  a_out_after_fall: assert property ($past(d1_f_oe) && d1_f_oe && $changed(d1_f) |-> !sclk)
    else $error("flash output changed while link clock high");
  a_host_hold_rise: assert property ($rose(sclk) && !cs_b |=> $stable(d0_h)[*3])
    else $error("host data moved right after a rising edge");
  a_select_clock_quiet: assert property ($fell(cs_b) |-> $stable(sclk) ##1 $stable(sclk)[*3])
    else $error("link clock moved at chip select fall");
  a_opcode_no_drive: assert property (!cs_b && rise_cnt_q < 6'h08 |-> !d0_f_oe && !d1_f_oe)
    else $error("flash drove a line during the opcode");
  a_deselect_gap: assert property ($rose(cs_b) |-> cs_b[*4])
    else $error("chip select high too briefly");
  a_clock_half_min: assert property ($changed(sclk) |=> $stable(sclk)[*3])
    else $error("link clock half period too short");
  a_oe_release: assert property ($rose(cs_b) |-> ##[0:3] (!d0_f_oe && !d1_f_oe))
    else $error("flash kept driving after deselect");
endmodule

//--- test/serial_flash_spi_front_end_tb.sv
// Self-checking bench joining the host end and the flash front end
`timescale 1ns/100ps
module serial_flash_spi_front_end_tb;
  import flash_spi_pkg::*;
  logic clk, rst_b, start, mode3, busy, done, soft_reset_pulse;
  logic [7:0] opcode, wdata, rdata, sr1_active, nv, v;
  logic [23:0] addr, read_addr, a;
  logic [1:0] kind;
  int err_total, num_checks, pulses, m, i;
  int dual_oe, n0;

  flash_spi_if link_i ();
  flash_spi_host #(.DIV_HALF(8'h06)) flash_spi_host_i (.clk(clk), .rst_b(rst_b),
    .start(start), .mode3(mode3), .opcode(opcode), .addr(addr), .kind(kind), .wdata(wdata),
    .busy(busy), .done(done), .rdata(rdata), .link(link_i));
  flash_spi_front flash_spi_front_i (.clk(clk), .rst_b(rst_b), .link(link_i),
    .sr1_active(sr1_active), .soft_reset_pulse(soft_reset_pulse), .read_addr(read_addr));
  flash_spi_monitor flash_spi_monitor_i (.clk(clk), .rst_b(rst_b), .sclk(link_i.sclk),
    .cs_b(link_i.cs_b), .d0_h(link_i.d0_h), .d0_h_oe(link_i.d0_h_oe),
    .d1_h_oe(link_i.d1_h_oe), .d0_f_oe(link_i.d0_f_oe), .d1_f(link_i.d1_f),
    .d1_f_oe(link_i.d1_f_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
    if (link_i.d0_f_oe === 1'b1) dual_oe <= dual_oe + 1;
  end

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task stop_test;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One whole frame, waiting a bounded time for completion
  task cmd(input logic [7:0] op, input logic [1:0] k, input logic [23:0] ad,
    input logic [7:0] wd);
    int n;
    opcode = op;
    kind = k;
    addr = ad;
    wdata = wd;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check(24'(busy), 24'h000001);
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
    if (done !== 1'b1) begin
      err_total++;
      stop_test;
    end
    @(negedge clk);
    check(24'(busy), 24'h000000);
  endtask

  function logic [7:0] param_exp(input logic [23:0] ad);
    case (ad[7:0])
      PARAM_ADDR_6C: return PARAM_6C;
      PARAM_ADDR_6D: return PARAM_6D;
      PARAM_ADDR_6E: return PARAM_6E;
      PARAM_ADDR_6F: return PARAM_6F;
      default: return 8'hFF;
    endcase
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    start = 1'b0;
    mode3 = 1'b0;
    opcode = 8'h00;
    addr = 24'h000000;
    kind = 2'h0;
    wdata = 8'h00;
    rst_b = 1'b0;
    nv = 8'h00;
    pulses = 0;
    dual_oe = 0;
    n0 = 0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(14));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check(24'(sr1_active), 24'h000000);
    for (m = 0; m < 2; m++) begin
      mode3 = m[0];
      // Let the parked clock settle before chip select falls
      repeat (4) @(negedge clk);
      cmd(OP_READ_SR1, 2'h1, 24'h000000, 8'h00);
      check(24'(rdata & 8'hFC), 24'(nv & 8'hFC));
      cmd(OP_READ_SR2, 2'h1, 24'h000000, 8'h00);
      check(24'(rdata), 24'h000000);
      cmd(OP_WRITE_SR, 2'h2, 24'h000000, 8'($urandom));
      check(24'(sr1_active & 8'hFC), 24'(nv & 8'hFC));
      cmd(OP_WRITE_EN, 2'h0, 24'h000000, 8'h00);
      check(24'(sr1_active[1]), 24'h000001);
      nv = 8'($urandom);
      cmd(OP_WRITE_SR, 2'h2, 24'h000000, nv);
      check(24'(sr1_active & 8'hFC), 24'(nv & 8'hFC));
      v = 8'($urandom);
      cmd(OP_VOL_WEN, 2'h0, 24'h000000, 8'h00);
      cmd(OP_WRITE_SR, 2'h2, 24'h000000, v);
      check(24'(sr1_active & 8'hFC), 24'(v & 8'hFC));
      cmd(OP_READ_SR1, 2'h1, 24'h000000, 8'h00);
      check(24'(rdata & 8'hFC), 24'(v & 8'hFC));
      cmd(OP_RST_EN, 2'h0, 24'h000000, 8'h00);
      cmd(OP_READ_SR1, 2'h1, 24'h000000, 8'h00);
      cmd(OP_RESET, 2'h0, 24'h000000, 8'h00);
      check(24'(pulses), 24'(m));
      cmd(OP_RST_EN, 2'h0, 24'h000000, 8'h00);
      cmd(OP_RESET, 2'h0, 24'h000000, 8'h00);
      check(24'(pulses), 24'(m + 1));
      n0 = dual_oe;
      check(24'(sr1_active & 8'hFC), 24'(nv & 8'hFC));
      for (i = 0; i < 7; i++) begin
        a = (i < 5) ? 24'h00006B + 24'(i) : 24'($urandom);
        cmd(OP_READ_PARAM, 2'h3, a, 8'h00);
        check(24'(rdata), 24'(param_exp(a)));
        check(read_addr, a);
      end
      check(24'(dual_oe - n0), 24'h000000);
      a = 24'($urandom);
      n0 = dual_oe;
      cmd(OP_DUAL_OUT, 2'h3, a, 8'h00);
      check(24'(rdata), 24'h0000FF);
      check(24'(dual_oe > n0), 24'h000001);
      check(read_addr, a);
    end
    stop_test;
  end
endmodule
